/* File: hw/ssu_cfg.svh */
/*
 * Register map, field positions and reset values of the serial unit.
 * Assumes inclusion by bare name ahead of the unit and its package.
 */
`ifndef SSU_CFG_SVH
`define SSU_CFG_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define OFS_MODE    8'h00
`define OFS_CTRL    8'h04
`define OFS_STAT    8'h08
`define OFS_TXDATA  8'h0C
`define OFS_RXDATA  8'h10
`define OFS_BAUD    8'h14

// ****************************************
// Field positions
// ****************************************
`define MB_SYNC     0
`define MB_MPFMT    1
`define MB_PARITY   2
`define CB_TXEN     0
`define CB_RXEN     1
`define CB_IDWAIT   2
`define CB_TXEIE    3
`define CB_TXDIE    4
`define CB_RXIE     5
`define CB_CLOCK_ENABLE_BIT0     6
`define CB_CLOCK_ENABLE_BIT1     7
`define SB_TXEMPTY  0
`define SB_TXEND    1
`define SB_RXFULL   2
`define SB_OVERRUN  3
`define SB_FRAMING  4
`define SB_PARITY   5
`define SB_RXID     6
`define SB_TXID     7

// ****************************************
// Reset values, responses, character ends
// ****************************************
`define RST_BAUD    16'h0031
`define RST_FLAG    1'b1
`define RST_LINE    1'b1
`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2
`define LAST_SYNC   4'h7
`define LAST_MP     4'h8

`endif

/* File: hw/ssu_pkg.sv */
/*
 * Types of the serial unit: its whole state as one packed struct.
 * Assumes nothing of its surroundings.
 */
package ssu_pkg;
   typedef struct packed {
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [1:0]  rresp;
      logic [31:0] rdata;
      logic        rxdSync1, rxdSync2, sckSync1, sckSync2, sckPrev;
      logic        syncModeSelect, mpFormat, parityEnable;
      logic        txEnable, rxEnable, idWaitEnable;
      logic        txEmptyIntEnable, txEndIntEnable, rxIntEnable;
      logic        clockEnableBit0, clockEnableBit1;
      logic        txEmptyFlag, txEndFlag, rxFullFlag, overrunFlag;
      logic        rxIdBit, txIdBit;
      logic [7:0]  transmitDataReg, receiveDataReg;
      logic [8:0]  transmitShiftReg, receiveShiftReg;
      logic [3:0]  bitCnt;
      logic [15:0] baudDiv, baudCnt;
      logic        txActive, rxActive, sckLevel, txdLevel;
   } unit_state_s;
endpackage

/* File: hw/sync_serial_multiproc_unit.sv */
/*
 * Clocked synchronous serial unit with multiprocessor character format,
 * AXI4-Lite register slave and four level interrupt requests.
 * Assumes one 100 MHz clock, a synchronous active-high reset, and a
 * serial partner whose clock and data pins are asynchronous to clk.
 */
// Local design decisions: register access over AXI4-Lite and the address map.
// Overview of operation
// - Clock source chosen by clock enable bit 1 alone
// - Internal clock: eight pulses (nine in multiprocessor format), idle high
// - Empty flag clear: load shifter, set flag
// - Empty flag and enable raise request
// - Shift eight bits out (nine in multiprocessor format), LSB first
// - At bit seven (eight in multiprocessor format), reload if data waiting
// - Else set end flag, hold line, clock high unless receiver still running
// - End flag and enable raise request
// - Sync mode: receive errors block transmit start
// - Receiver starts in step with clock
// - Full receiver: overrun, drop, keep full
// - Good character: store, set full flag
// - No reception resume while errors set
// - Multiprocessor bit one marks ID
// - ID wait suppresses storing and flags
// - ID character: set bit, clear wait
// - Multiprocessor format ignores parity setting
// - Transmit ID bit sent as multiprocessor bit
// - Four requests from their flags
// - Empty and end flags set at reset
// - Sync characters eight bits, no parity
// - Data write clears empty flag
// - Transmit disable forces empty flag
`include "ssu_cfg.svh"

module sync_serial_multiproc_unit
   import ssu_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // AXI4-Lite slave
   input  wire logic [7:0]  awaddr,
   input  wire logic        awvalid,
   output wire logic        awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output wire logic        wready,
   output wire logic [1:0]  bresp,
   output wire logic        bvalid,
   input  wire logic        bready,
   input  wire logic [7:0]  araddr,
   input  wire logic        arvalid,
   output wire logic        arready,
   output wire logic [31:0] rdata,
   output wire logic [1:0]  rresp,
   output wire logic        rvalid,
   input  wire logic        rready,
   // Serial pins
   output wire logic        txdOut,
   input  wire logic        rxdIn,
   input  wire logic        serialClockPinIn,
   output wire logic        serialClockPinOut,
   output wire logic        serialClockPinOe,
   // Interrupt requests
   output wire logic        rxFullIrq,
   output wire logic        txEmptyIrq,
   output wire logic        txEndIrq,
   output wire logic        rxErrorIrq
);

   // ****************************************
   // State and helpers
   // ****************************************
   unit_state_s st_r;
   unit_state_s st_nxt;
   logic        wrFire;
   logic        rdFire;
   logic        busy;
   logic        tick;
   logic        fallEv;
   logic        riseEv;
   logic        charDone;
   logic        canTx;
   logic        errBlock;
   logic        mpMode;
   logic        mpBit;
   logic [7:0]  rxByte;
   logic [3:0]  lastIdx;

   // Offsets that answer OKAY
   function automatic logic isMapped(input logic [7:0] a);
      case (a)
         `OFS_MODE, `OFS_CTRL, `OFS_STAT,
         `OFS_TXDATA, `OFS_RXDATA, `OFS_BAUD: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction

   // Read mux; unmapped and reserved bits read zero
   function automatic logic [31:0] readWord(input unit_state_s s, input logic [7:0] a);
      logic [31:0] w;
      w = 32'h0000_0000;
      case (a)
         `OFS_MODE:
         begin
            w[`MB_SYNC]   = s.syncModeSelect;
            w[`MB_MPFMT]  = s.mpFormat;
            w[`MB_PARITY] = s.parityEnable;
         end
         `OFS_CTRL:
         begin
            w[`CB_TXEN]   = s.txEnable;
            w[`CB_RXEN]   = s.rxEnable;
            w[`CB_IDWAIT] = s.idWaitEnable;
            w[`CB_TXEIE]  = s.txEmptyIntEnable;
            w[`CB_TXDIE]  = s.txEndIntEnable;
            w[`CB_RXIE]   = s.rxIntEnable;
            w[`CB_CLOCK_ENABLE_BIT0]   = s.clockEnableBit0;
            w[`CB_CLOCK_ENABLE_BIT1]   = s.clockEnableBit1;
         end
         `OFS_STAT:
         begin
            w[`SB_TXEMPTY] = s.txEmptyFlag;
            w[`SB_TXEND]   = s.txEndFlag;
            w[`SB_RXFULL]  = s.rxFullFlag;
            w[`SB_OVERRUN] = s.overrunFlag;
            w[`SB_RXID]    = s.rxIdBit;
            w[`SB_TXID]    = s.txIdBit;
         end
         `OFS_TXDATA: w[7:0] = s.transmitDataReg;
         `OFS_RXDATA: w[7:0] = s.receiveDataReg;
         `OFS_BAUD:   w[15:0] = s.baudDiv;
         default:     w = 32'h0000_0000;
      endcase
      return w;
   endfunction

   // Handshakes: one write and one read outstanding at most
   assign wrFire  = awvalid & wvalid & ~st_r.bvalid;
   assign rdFire  = arvalid & ~st_r.rvalid;
   assign awready = wrFire;
   assign wready  = wrFire;
   assign arready = ~st_r.rvalid;
   assign busy    = st_r.txActive | st_r.rxActive;
   assign mpMode  = st_r.mpFormat & ~st_r.syncModeSelect;
   // Framing and parity never occur in this frame, so overrun alone blocks
   assign errBlock = st_r.overrunFlag;
   assign canTx    = st_r.txEnable & ~st_r.txEmptyFlag
                   & ~(st_r.syncModeSelect & errBlock);
   assign lastIdx  = mpMode ? `LAST_MP : `LAST_SYNC;

   // ****************************************
   // Next-state logic
   // ****************************************
   always_comb
   begin
      st_nxt   = st_r;
      tick     = 1'b0;
      fallEv   = 1'b0;
      riseEv   = 1'b0;
      charDone = 1'b0;
      mpBit    = 1'b0;
      rxByte   = 8'h00;

      // Pin synchronisers
      st_nxt.rxdSync1 = rxdIn;
      st_nxt.rxdSync2 = st_r.rxdSync1;
      st_nxt.sckSync1 = serialClockPinIn;
      st_nxt.sckSync2 = st_r.sckSync1;
      st_nxt.sckPrev  = st_r.sckSync2;

      // Response channels release on their ready
      if (st_r.bvalid && bready)
         st_nxt.bvalid = 1'b0;
      if (st_r.rvalid && rready)
         st_nxt.rvalid = 1'b0;
      if (rdFire)
      begin
         st_nxt.rvalid = 1'b1;
         st_nxt.rdata  = readWord(st_r, araddr);
         st_nxt.rresp  = isMapped(araddr) ? `RESP_OKAY : `RESP_SLVERR;
         if (araddr == `OFS_RXDATA)
            st_nxt.rxFullFlag = 1'b0;
      end

      // Register writes; hardware sets below override clears
      if (wrFire)
      begin
         st_nxt.bvalid = 1'b1;
         st_nxt.bresp  = isMapped(awaddr) ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (wrFire && wstrb[0])
      begin
         case (awaddr)
            `OFS_MODE:
            begin
               st_nxt.syncModeSelect = wdata[`MB_SYNC];
               st_nxt.mpFormat       = wdata[`MB_MPFMT];
               st_nxt.parityEnable   = wdata[`MB_PARITY];
            end
            `OFS_CTRL:
            begin
               st_nxt.txEnable         = wdata[`CB_TXEN];
               st_nxt.rxEnable         = wdata[`CB_RXEN];
               st_nxt.idWaitEnable     = wdata[`CB_IDWAIT];
               st_nxt.txEmptyIntEnable = wdata[`CB_TXEIE];
               st_nxt.txEndIntEnable   = wdata[`CB_TXDIE];
               st_nxt.rxIntEnable      = wdata[`CB_RXIE];
               st_nxt.clockEnableBit0  = wdata[`CB_CLOCK_ENABLE_BIT0];
               st_nxt.clockEnableBit1  = wdata[`CB_CLOCK_ENABLE_BIT1];
            end
            `OFS_STAT:
            begin
               // Full and overrun flags clear by writing zero; ones leave them alone
               if (!wdata[`SB_RXFULL])
                  st_nxt.rxFullFlag = 1'b0;
               if (!wdata[`SB_OVERRUN])
                  st_nxt.overrunFlag = 1'b0;
               st_nxt.txIdBit = wdata[`SB_TXID];
            end
            `OFS_TXDATA:
            begin
               st_nxt.transmitDataReg = wdata[7:0];
               st_nxt.txEmptyFlag     = 1'b0;
            end
            `OFS_BAUD:
            begin
               st_nxt.baudDiv[7:0] = wdata[7:0];
               if (wstrb[1])
                  st_nxt.baudDiv[15:8] = wdata[15:8];
            end
            default: ;
         endcase
      end

      // Baud generator: free running, one tick per half bit period
      if (st_r.baudCnt >= st_r.baudDiv)
      begin
         st_nxt.baudCnt = 16'h0000;
         tick = 1'b1;
      end
      else
         st_nxt.baudCnt = st_r.baudCnt + 16'h0001;

      // Clock source: external pin edges or internal toggling
      if (st_r.clockEnableBit1)
      begin
         fallEv = busy & st_r.sckPrev & ~st_r.sckSync2;
         riseEv = busy & ~st_r.sckPrev & st_r.sckSync2;
      end
      else if (busy && tick)
      begin
         fallEv = st_r.sckLevel;
         riseEv = ~st_r.sckLevel;
         st_nxt.sckLevel = ~st_r.sckLevel;
      end

      // Falling edge drives the next data bit
      if (fallEv && st_r.txActive)
      begin
         st_nxt.txdLevel = st_r.transmitShiftReg[0];
         st_nxt.transmitShiftReg = st_r.transmitShiftReg >> 1;
      end

      // Rising edge samples and counts; last rise ends the character
      if (riseEv)
      begin
         st_nxt.receiveShiftReg = {st_r.rxdSync2, st_r.receiveShiftReg[8:1]};
         if (st_r.bitCnt == lastIdx)
         begin
            charDone = 1'b1;
            st_nxt.bitCnt = 4'h0;
         end
         else
            st_nxt.bitCnt = st_r.bitCnt + 4'h1;
      end
      mpBit  = mpMode & st_nxt.receiveShiftReg[8];
      rxByte = mpMode ? st_nxt.receiveShiftReg[7:0] : st_nxt.receiveShiftReg[8:1];

      // Received character: ID wait filter, overrun or store
      if (charDone && st_r.rxActive && !(st_r.idWaitEnable && !mpBit))
      begin
         if (st_r.rxFullFlag)
            st_nxt.overrunFlag = 1'b1;
         else
         begin
            st_nxt.receiveDataReg = rxByte;
            st_nxt.rxFullFlag     = 1'b1;
         end
         if (mpMode)
         begin
            st_nxt.rxIdBit = mpBit;
            if (mpBit)
               st_nxt.idWaitEnable = 1'b0;
         end
      end

      // Character boundary: decide whether each side carries on
      if (charDone)
      begin
         st_nxt.txActive = 1'b0;
         if (st_r.txActive && !canTx)
            st_nxt.txEndFlag = 1'b1;
         st_nxt.rxActive = st_r.rxActive & st_r.rxEnable
                         & ~st_nxt.overrunFlag;
      end
      if ((!busy || charDone) && canTx)
      begin
         // Reload straight after the last bit, so no gap appears
         st_nxt.transmitShiftReg = {st_r.txIdBit, st_r.transmitDataReg};
         st_nxt.txEmptyFlag = 1'b1;
         st_nxt.txEndFlag   = 1'b0;
         st_nxt.txActive    = 1'b1;
         if (st_r.rxEnable && !errBlock && !busy)
            st_nxt.rxActive = 1'b1;
      end
      else if (!busy && st_r.rxEnable && !errBlock)
         st_nxt.rxActive = 1'b1;
      if (!busy)
      begin
         st_nxt.bitCnt   = 4'h0;
         st_nxt.sckLevel = `RST_LINE;
      end

      // Transmitter disabled: abandon the character, report empty
      if (!st_r.txEnable)
      begin
         st_nxt.txEmptyFlag = 1'b1;
         st_nxt.txActive    = 1'b0;
      end

      // Synchronous reset
      if (rst)
      begin
         st_nxt             = '0;
         st_nxt.baudDiv     = `RST_BAUD;
         st_nxt.txEmptyFlag = `RST_FLAG;
         st_nxt.txEndFlag   = `RST_FLAG;
         st_nxt.txdLevel    = `RST_LINE;
         st_nxt.sckLevel    = `RST_LINE;
         st_nxt.rxdSync1    = `RST_LINE;
         st_nxt.rxdSync2    = `RST_LINE;
         st_nxt.sckSync1    = `RST_LINE;
         st_nxt.sckSync2    = `RST_LINE;
         st_nxt.sckPrev     = `RST_LINE;
      end
   end

   // State register
   always_ff @(posedge clk)
   begin
      st_r <= st_nxt;
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign bvalid  = st_r.bvalid;
   assign bresp   = st_r.bresp;
   assign rvalid  = st_r.rvalid;
   assign rdata   = st_r.rdata;
   assign rresp   = st_r.rresp;
   assign txdOut  = st_r.txdLevel;
   assign serialClockPinOut = st_r.sckLevel;
   // Pin driven only when the internal clock is output
   assign serialClockPinOe  = ~st_r.clockEnableBit1
                            & (st_r.syncModeSelect | st_r.clockEnableBit0);

   // Level requests straight from flags and enables
   assign rxFullIrq  = st_r.rxFullFlag & st_r.rxIntEnable;
   assign txEmptyIrq = st_r.txEmptyFlag & st_r.txEmptyIntEnable;
   assign txEndIrq   = st_r.txEndFlag & st_r.txEndIntEnable;
   assign rxErrorIrq = st_r.overrunFlag & st_r.rxIntEnable;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   sequence s_rx_end;
      charDone && st_r.rxActive && !rdFire && !wrFire;
   endsequence

   sequence s_pass;
      !(st_r.idWaitEnable && !mpBit);
   endsequence

   a_sck_idle_high: assert property (
      (!busy ##1 !busy) |-> st_r.sckLevel)
      else $error("clock pin not high while idle");

   a_tx_load_flag: assert property (
      (!busy && canTx) |=> st_r.txEmptyFlag && st_r.txActive)
      else $error("transmit load did not set empty flag");

   a_lsb_first: assert property (
      (fallEv && st_r.txActive) |=> txdOut == $past(st_r.transmitShiftReg[0]))
      else $error("serial bit out of order");

   a_end_flag_set: assert property (
      ($fell(st_r.txActive) && st_r.txEnable) |-> st_r.txEndFlag)
      else $error("transmit end flag not set");

   a_error_blocks_tx: assert property (
      (st_r.syncModeSelect && st_r.overrunFlag && !busy) |=> !st_r.txActive)
      else $error("transmit started with error flag set");

   a_overrun_keep: assert property (
      (s_rx_end ##0 s_pass ##0 st_r.rxFullFlag) |=>
         st_r.overrunFlag && st_r.rxFullFlag && $stable(st_r.receiveDataReg))
      else $error("overrun handling wrong");

   a_rx_store: assert property (
      (s_rx_end ##0 s_pass ##0 !st_r.rxFullFlag) |=>
         st_r.rxFullFlag && st_r.receiveDataReg == $past(rxByte))
      else $error("received character not stored");

   a_id_wake: assert property (
      (s_rx_end ##0 (mpMode && st_r.idWaitEnable && mpBit)) |=>
         !st_r.idWaitEnable && st_r.rxIdBit)
      else $error("ID character did not end wait");

   a_reset_flags: assert property (
      $fell(rst) |-> st_r.txEmptyFlag && st_r.txEndFlag)
      else $error("flags not set after reset");

   a_char_length: assert property (
      st_r.bitCnt <= lastIdx)
      else $error("bit count beyond character");

   a_write_clears: assert property (
      (wrFire && wstrb[0] && awaddr == `OFS_TXDATA && st_r.txEnable
         && busy && !charDone) |=> !st_r.txEmptyFlag)
      else $error("data write left empty flag set");

   a_disable_empty: assert property (
      !st_r.txEnable |=> st_r.txEmptyFlag)
      else $error("disabled transmitter not empty");

endmodule

/* File: test/serial_peer_model.sv */
/*
 * Far-side station of the serial unit: clocked serial peer.
 * Assumes the unit's serial pins as ports and a pull-up on the clock pin.
 */
module serial_peer_model
(
   // Unit pins
   input  wire logic        txdOut,
   input  wire logic        serialClockPinOut,
   input  wire logic        serialClockPinOe,
   output      logic        rxdIn,
   output wire logic        serialClockPinIn,
   // Observation
   output      logic [15:0] hist,
   output      int          rises
);
   timeunit 1ns;
   timeprecision 100ps;

   logic extDrive = 1'b1;
   logic bitQ[$];

   // Wire level: unit when driving, else our clock, idle via pull-up
   assign serialClockPinIn = serialClockPinOe ? serialClockPinOut : extDrive;

   initial
   begin
      rxdIn = 1'b1;
      hist  = '0;
      rises = 0;
   end

   // Take the unit's data on rising edges
   always @(posedge serialClockPinIn)
   begin
      hist  <= {txdOut, hist[15:1]};
      rises <= rises + 1;
   end

   // Next bit on falling edges; drained queue keeps the line changing
   always @(negedge serialClockPinIn)
      rxdIn <= (bitQ.size() > 0) ? bitQ.pop_front() : ~rxdIn;

   // Queue one character, LSB first, ninth bit marks an ID
   task automatic send(input logic [8:0] w, input int n);
      for (int i = 0; i < n; i++)
         bitQ.push_back(w[i]);
   endtask

   // External clock burst, 125 ns period, stands high outside it
   task automatic burst(input int n);
      repeat (n)
      begin
         #62.5 extDrive = 1'b0;
         #62.5 extDrive = 1'b1;
      end
   endtask
endmodule

/* File: test/testbench.sv */
/*
 * Self-checking bench of the serial unit over AXI4-Lite.
 * Assumes the unit, its package and header, and the serial peer model.
 */
`include "ssu_cfg.svh"

module testbench;
   timeunit 1ns;
   timeprecision 100ps;

   // ********
   // Signals
   // ********
   logic        clk, rst, awvalid, wvalid, bready, arvalid, rready;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdv;
   logic [3:0]  wstrb;
   logic [1:0]  resp;
   wire  logic  awready, wready, bvalid, arready, rvalid, txdOut, rxdIn;
   wire  logic  serialClockPinIn, serialClockPinOut, serialClockPinOe;
   wire  logic  rxFullIrq, txEmptyIrq, txEndIrq, rxErrorIrq;
   wire  logic [1:0]  bresp, rresp;
   wire  logic [31:0] rdata;
   logic [15:0] hist;
   int          rises, mismatches, checked;

   localparam logic [7:0] EN_TX = 8'h01 << `CB_TXEN;
   localparam logic [7:0] EN_RX = 8'h01 << `CB_RXEN;
   localparam logic [7:0] ID_WAIT = 8'h01 << `CB_IDWAIT;
   localparam logic [7:0] IE_EMPTY = 8'h01 << `CB_TXEIE;
   localparam logic [7:0] IE_END = 8'h01 << `CB_TXDIE;
   localparam logic [7:0] IE_RX = 8'h01 << `CB_RXIE;
   localparam logic [7:0] CK_OUT = 8'h01 << `CB_CLOCK_ENABLE_BIT0;
   localparam logic [7:0] CK_EXT = 8'h01 << `CB_CLOCK_ENABLE_BIT1;
   localparam logic [7:0] SYNC_MODE = 8'h01 << `MB_SYNC;
   localparam logic [7:0] MP_MODE = 8'h01 << `MB_MPFMT;
   localparam logic [7:0] PAR_ON = 8'h01 << `MB_PARITY;
   localparam logic [7:0] ST_EMPTY = 8'h01 << `SB_TXEMPTY;
   localparam logic [7:0] ST_END = 8'h01 << `SB_TXEND;
   localparam logic [7:0] ST_FULL = 8'h01 << `SB_RXFULL;
   localparam logic [7:0] ST_OVR = 8'h01 << `SB_OVERRUN;
   localparam logic [7:0] ST_RXID = 8'h01 << `SB_RXID;
   localparam logic [7:0] ST_TXID = 8'h01 << `SB_TXID;

   sync_serial_multiproc_unit i_dut
   (
      .clk, .rst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
      .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
      .rdata, .rresp, .rvalid, .rready, .txdOut, .rxdIn, .serialClockPinIn,
      .serialClockPinOut, .serialClockPinOe, .rxFullIrq, .txEmptyIrq,
      .txEndIrq, .rxErrorIrq
   );

   serial_peer_model i_peer
   (
      .txdOut, .serialClockPinOut, .serialClockPinOe, .rxdIn,
      .serialClockPinIn, .hist, .rises
   );

   // 100 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // ********
   // Tasks
   // ********
   task automatic tally_and_finish;
      if (mismatches == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic hang;
      mismatches++;
      $display("ERROR %0t: wait ran out", $time);
      tally_and_finish();
   endtask

   // Write: address and data offered together, response taken after
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      int n;
      @(posedge clk);
      awaddr  <= a;
      wdata   <= 32'(d);
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      n = 0;
      do @(negedge clk); while (awready !== 1'b1 && ++n < 100);
      @(posedge clk);
      awvalid <= 1'b0;
      wvalid  <= 1'b0;
      bready  <= 1'b1;
      do @(negedge clk); while (bvalid !== 1'b1 && ++n < 200);
      resp = bresp;
      @(posedge clk);
      bready <= 1'b0;
      if (n >= 200) hang();
   endtask

   // Read: data and response captured at the rvalid edge
   task automatic rd(input logic [7:0] a);
      int n;
      @(posedge clk);
      araddr  <= a;
      arvalid <= 1'b1;
      n = 0;
      do @(negedge clk); while (arready !== 1'b1 && ++n < 100);
      @(posedge clk);
      arvalid <= 1'b0;
      rready  <= 1'b1;
      do @(negedge clk); while (rvalid !== 1'b1 && ++n < 200);
      rdv  = rdata;
      resp = rresp;
      @(posedge clk);
      rready <= 1'b0;
      if (n >= 200) hang();
   endtask

   task automatic chkReg(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
      rd(a);
      checked++;
      if ((rdv[7:0] & m) !== e)
      begin
         mismatches++;
         $display("ERROR %0t: reg %h read %h, expected %h", $time, a, rdv[7:0], e);
      end
   endtask

   task automatic chkPin(input logic got, input logic exp);
      checked++;
      if (got !== exp)
      begin
         mismatches++;
         $display("ERROR %0t: level %b, expected %b", $time, got, exp);
      end
   endtask

   // Settled outputs are looked at mid-cycle
   task automatic settle;
      @(negedge clk);
   endtask

   task automatic waitBit(input logic [7:0] a, input int b);
      int n;
      n = 0;
      do
      begin
         rd(a);
         n++;
      end
      while (rdv[b] !== 1'b1 && n < 300);
      if (rdv[b] !== 1'b1) hang();
   endtask

   // ********
   // Sequence
   // ********
   initial
   begin
      int base;
      {rst, wstrb} = {1'b1, 4'hF};
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata} = '0;
      {mismatches, checked} = '0;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      // Reset flags, unmapped address, requests from reset flags
      chkReg(`OFS_STAT, 8'hFF, ST_EMPTY | ST_END);
      chkReg(8'h18, 8'hFF, 8'h00);
      chkPin(resp === `RESP_SLVERR, 1'b1);
      wr(`OFS_CTRL, IE_EMPTY | IE_END);
      settle();
      chkPin(txEmptyIrq, 1'b1);
      chkPin(txEndIrq, 1'b1);
      chkPin(rxErrorIrq, 1'b0);
      // Two characters back to back on the internal clock
      wr(`OFS_BAUD, 8'h03);
      wr(`OFS_MODE, SYNC_MODE);
      wr(`OFS_CTRL, EN_TX | IE_EMPTY | IE_END);
      settle();
      chkPin(serialClockPinOe, 1'b1);
      base = rises;
      wr(`OFS_TXDATA, 8'hA5);
      chkReg(`OFS_STAT, ST_EMPTY | ST_END, ST_EMPTY);
      wr(`OFS_TXDATA, 8'h3C);
      chkReg(`OFS_STAT, ST_EMPTY, 8'h00);
      settle();
      chkPin(txEmptyIrq, 1'b0);
      chkPin(txEndIrq, 1'b0);
      waitBit(`OFS_STAT, `SB_TXEND);
      settle();
      chkPin(hist === 16'h3CA5, 1'b1);
      chkPin(rises - base == 16, 1'b1);
      chkPin(serialClockPinOut, 1'b1);
      chkPin(txdOut, 1'b0);
      chkPin(txEndIrq, 1'b1);
      // Second character meets a full receiver
      i_peer.send(9'h05A, 8);
      i_peer.send(9'h0C3, 8);
      chkReg(`OFS_STAT, ST_EMPTY | ST_END, ST_EMPTY | ST_END);
      wr(`OFS_CTRL, 8'h00);
      wr(`OFS_CTRL, EN_TX | EN_RX | IE_RX);
      waitBit(`OFS_STAT, `SB_OVERRUN);
      settle();
      chkPin(rxErrorIrq, 1'b1);
      chkPin(rxFullIrq, 1'b1);
      chkReg(`OFS_STAT, ST_FULL | ST_OVR, ST_FULL | ST_OVR);
      chkReg(`OFS_RXDATA, 8'hFF, 8'h5A);
      // Overrun holds back a transmit start; disabling the transmitter then reports empty
      wr(`OFS_CTRL, EN_TX | IE_RX);
      base = rises;
      wr(`OFS_TXDATA, 8'h81);
      repeat (10) chkReg(`OFS_STAT, ST_EMPTY, 8'h00);
      chkPin(rises == base, 1'b1);
      wr(`OFS_CTRL, IE_RX);
      chkReg(`OFS_STAT, ST_EMPTY, ST_EMPTY);
      wr(`OFS_STAT, 8'h00);
      chkReg(`OFS_STAT, ST_FULL | ST_OVR, 8'h00);
      settle();
      chkPin(rxErrorIrq, 1'b0);
      // Multiprocessor format: ID bit sent ninth, parity ignored
      wr(`OFS_MODE, MP_MODE | PAR_ON);
      wr(`OFS_STAT, ST_TXID);
      wr(`OFS_CTRL, EN_TX | CK_OUT);
      wr(`OFS_TXDATA, 8'h47);
      chkReg(`OFS_STAT, ST_END, 8'h00);
      waitBit(`OFS_STAT, `SB_TXEND);
      chkPin(hist[15:7] === 9'h147, 1'b1);
      // Data character skipped while waiting for an ID
      i_peer.send(9'h011, 9);
      i_peer.send(9'h122, 9);
      wr(`OFS_CTRL, EN_RX | ID_WAIT | IE_RX | CK_OUT);
      waitBit(`OFS_STAT, `SB_RXFULL);
      settle();
      chkPin(rxFullIrq, 1'b1);
      chkReg(`OFS_STAT, ST_RXID, ST_RXID);
      chkReg(`OFS_CTRL, ID_WAIT, 8'h00);
      chkReg(`OFS_RXDATA, 8'hFF, 8'h22);
      // External clock, duplex: receiver stops, flags cleared, one write enables both
      wr(`OFS_CTRL, 8'h00);
      // Longest character at this divisor is 72 cycles; a mode change mid-character corrupts it
      repeat (100) @(posedge clk);
      wr(`OFS_STAT, 8'h00);
      chkReg(`OFS_STAT, ST_FULL | ST_OVR, 8'h00);
      wr(`OFS_MODE, SYNC_MODE);
      i_peer.send(9'h069, 8);
      wr(`OFS_CTRL, EN_TX | EN_RX | CK_EXT);
      settle();
      chkPin(serialClockPinOe, 1'b0);
      base = rises;
      // Shared engine: the pending character joins at the receiver's boundary
      wr(`OFS_TXDATA, 8'h96);
      i_peer.burst(16);
      waitBit(`OFS_STAT, `SB_TXEND);
      chkPin(hist[15:8] === 8'h96, 1'b1);
      chkPin(rises - base == 16, 1'b1);
      chkReg(`OFS_RXDATA, 8'hFF, 8'h69);
      tally_and_finish();
   end
endmodule
